// ===== hdl/fault_limit_status_bank.v
// fault limits, fault responses and status flags behind the serial bus
`timescale 1ns/1ps
`include "fault_bank_regs.vh"

module fault_limit_status_bank #(
  parameter [6:0] BUS_ADDR = 7'h58,
  parameter N_TEMP = 3,
  parameter [15:0] LV_FAULT_LEVEL = 16'h0006
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oe,
  output reg o_alert_n,
  output reg o_output_en,
  input wire [15:0] i_vout,
  input wire [15:0] i_iout,
  input wire [15:0] i_vin,
  input wire [16*N_TEMP-1:0] i_temps,
  input wire i_input_lost,
  input wire i_current_limiting,
  input wire i_restart,
  input wire i_busy,
  input wire i_power_not_good,
  input wire i_vout_ov_fault,
  input wire i_vout_ov_warn,
  input wire i_vout_uv_warn,
  input wire i_share_fault,
  input wire i_power_limiting,
  input wire i_iin_over_current,
  input wire i_fan1_fault,
  input wire i_fan_override
);
  localparam NF = 22;
  localparam NL = 9;

  wire start, stop, wr_stb, rd_next;
  wire [7:0] wr_data;
  reg [7:0] rd_byte;

  reg [15:0] lim_q [0:NL-1];
  reg [7:0] ot_act_q;
  reg [7:0] cmd_q;
  reg [7:0] lsb_q;
  reg [1:0] wcnt_q;
  reg [1:0] rptr_q;
  reg [NF-1:0] flag_q;
  reg ot_latch_q;
  reg bad_cmd, bad_data, comm_other, clr;
  reg [15:0] rd_val;
  reg rd_two;
  wire [NF-1:0] ev;
  wire [15:0] hot;
  wire trip, ot_f;
  wire [15:0] wval;
  integer k;

  // limit index of a command, NL when not a limit
  function [3:0] lim_idx;
    input [7:0] c;
    begin
      case (c)
        `OFS_VOUT_UV_LVL: lim_idx = 4'd0;
        `OFS_OC_LVL: lim_idx = 4'd1;
        `OFS_OC_WARN: lim_idx = 4'd2;
        `OFS_OT_LVL: lim_idx = 4'd3;
        `OFS_OT_WARN: lim_idx = 4'd4;
        `OFS_VIN_OV_LVL: lim_idx = 4'd5;
        `OFS_VIN_OV_WARN: lim_idx = 4'd6;
        `OFS_VIN_UV_WARN: lim_idx = 4'd7;
        `OFS_VIN_UV_LVL: lim_idx = 4'd8;
        default: lim_idx = 4'd9;
      endcase
    end
  endfunction

  // any command this bank answers
  function known;
    input [7:0] c;
    begin
      case (c)
        `CMD_CLEAR_FAULTS, `OFS_VOUT_UV_ACT, `OFS_OC_ACT,
        `OFS_OT_ACT, `OFS_VIN_OV_ACT, `OFS_VIN_UV_ACT,
        `OFS_STAT_BYTE, `OFS_STAT_WORD, `OFS_STAT_VOUT,
        `OFS_STAT_IOUT, `OFS_STAT_INPUT, `OFS_STAT_TEMP,
        `OFS_STAT_COMM, `OFS_STAT_FANS: known = 1'b1;
        default: known = (lim_idx(c) != 4'd9);
      endcase
    end
  endfunction

  serial_byte_slave #(
    .ADDR(BUS_ADDR)
  ) u_link (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .o_start(start),
    .o_stop(stop),
    .o_wr_stb(wr_stb),
    .o_wr_data(wr_data),
    .o_rd_next(rd_next),
    .i_rd_data(rd_byte)
  );

  // open drain: only ever pulls low
  assign o_sda = 1'b0;

  // hottest sensor by a compare chain
  genvar g;
  generate
    for (g = 0; g < N_TEMP; g = g + 1) begin : g_hot
      wire [15:0] t = i_temps[16*g +: 16];
      wire [15:0] m;
      if (g == 0) begin : g_first
        assign m = t;
      end else begin : g_next
        assign m = (t > g_hot[g-1].m) ? t : g_hot[g-1].m;
      end
    end
  endgenerate
  assign hot = g_hot[N_TEMP-1].m;

  // live fault and warning conditions
  assign ev[0] = o_output_en & ~i_input_lost &
                 (i_vout < lim_q[0]);
  assign ev[1] = i_vout_ov_fault;
  assign ev[2] = i_vout_ov_warn;
  assign ev[3] = i_vout_uv_warn;
  assign ev[4] = i_iout > lim_q[1];
  assign ev[5] = i_current_limiting & o_output_en &
                 (i_vout < LV_FAULT_LEVEL);
  assign ev[6] = i_iout > lim_q[2];
  assign ev[7] = i_share_fault;
  assign ev[8] = i_power_limiting;
  assign ev[9] = i_vin > lim_q[5];
  assign ev[10] = i_vin > lim_q[6];
  assign ev[11] = i_vin < lim_q[7];
  assign ev[12] = i_vin < lim_q[8];
  assign ev[13] = i_input_lost;
  assign ev[14] = i_iin_over_current;
  assign ev[15] = ot_f;
  assign ev[16] = hot > lim_q[4];
  assign ev[17] = i_fan1_fault;
  assign ev[18] = i_fan_override;
  assign ev[19] = bad_cmd;
  assign ev[20] = bad_data;
  assign ev[21] = comm_other;

  assign ot_f = hot > lim_q[3];
  assign trip = ev[0] | ev[4] | ev[5] | ev[9] | ev[12] | ot_f;
  assign wval = {wr_data, lsb_q};

  // sticky flags, set beats clear
  generate
    for (g = 0; g < NF; g = g + 1) begin : g_flag
      always @(posedge i_clk) begin
        if (i_rst)
          flag_q[g] <= 1'b0;
        else
          flag_q[g] <= ev[g] | (flag_q[g] & ~clr);
      end
    end
  endgenerate

  // output enable, alert and temperature latch
  always @(posedge i_clk) begin
    if (i_rst) begin
      ot_latch_q <= 1'b0;
      o_output_en <= 1'b0;
      o_alert_n <= 1'b1;
    end else begin
      if (ot_f && ot_act_q == `ACT_LATCHED)
        ot_latch_q <= 1'b1;
      else if (i_restart)
        ot_latch_q <= 1'b0;
      o_output_en <= ~trip & ~ot_latch_q;
      o_alert_n <= ~(|flag_q);
    end
  end

  // write and read side strobes decoded from bus bytes
  always @* begin
    bad_cmd = 1'b0;
    bad_data = 1'b0;
    comm_other = 1'b0;
    clr = 1'b0;
    if (wr_stb) begin
      if (wcnt_q == 2'd0)
        bad_cmd = ~known(wr_data);
      else if (wcnt_q == 2'd1 && lim_idx(cmd_q) == 4'd9)
        bad_data = (cmd_q != `OFS_OT_ACT) ||
                   (wr_data != `ACT_LATCHED &&
                    wr_data != `ACT_HICCUP);
      else if (wcnt_q == 2'd2)
        bad_data = (lim_idx(cmd_q) == 4'd5 &&
                    wval > `RST_VIN_OV_LVL) ||
                   (lim_idx(cmd_q) == 4'd7 &&
                    wval < `RST_VIN_UV_WARN) ||
                   (lim_idx(cmd_q) == 4'd8 &&
                    wval < `RST_VIN_UV_LVL);
      else if (wcnt_q == 2'd3)
        bad_data = 1'b1;
    end
    if (rd_next && (rptr_q > 2'd1 || (rptr_q == 2'd1 && !rd_two)))
      comm_other = 1'b1;
    if (stop && wcnt_q == 2'd1 && cmd_q == `CMD_CLEAR_FAULTS)
      clr = 1'b1;
  end

  // bus byte counter and register writes
  always @(posedge i_clk) begin
    if (i_rst) begin
      cmd_q <= 8'h00;
      lsb_q <= 8'h00;
      wcnt_q <= 2'd0;
      rptr_q <= 2'd0;
      ot_act_q <= `RST_OT_ACT;
      lim_q[0] <= `RST_VOUT_UV_LVL;
      lim_q[1] <= `RST_OC_LVL;
      lim_q[2] <= `RST_OC_WARN;
      lim_q[3] <= `RST_OT_LVL;
      lim_q[4] <= `RST_OT_WARN;
      lim_q[5] <= `RST_VIN_OV_LVL;
      lim_q[6] <= `RST_VIN_OV_WARN;
      lim_q[7] <= `RST_VIN_UV_WARN;
      lim_q[8] <= `RST_VIN_UV_LVL;
    end else begin
      if (start)
        wcnt_q <= 2'd0;
      else if (wr_stb && wcnt_q != 2'd3)
        wcnt_q <= wcnt_q + 2'd1;
      if (wr_stb && wcnt_q == 2'd0) begin
        cmd_q <= wr_data;
        rptr_q <= 2'd0;
      end
      if (wr_stb && wcnt_q == 2'd1) begin
        lsb_q <= wr_data;
        if (cmd_q == `OFS_OT_ACT && !bad_data)
          ot_act_q <= wr_data;
      end
      for (k = 0; k < NL; k = k + 1) begin
        if (wr_stb && wcnt_q == 2'd2 && !bad_data &&
            lim_idx(cmd_q) == k[3:0])
          lim_q[k] <= wval;
      end
      if (rd_next && rptr_q != 2'd3)
        rptr_q <= rptr_q + 2'd1;
    end
  end

  // status bytes
  wire [7:0] st_vout = {flag_q[1], flag_q[2], flag_q[3],
                        flag_q[0], 4'h0};
  wire [7:0] st_iout = {flag_q[4], flag_q[5], flag_q[6], 1'b0,
                        flag_q[7], flag_q[8], 2'b00};
  wire [7:0] st_in = {flag_q[9], flag_q[10], flag_q[11],
                      flag_q[12], flag_q[13], flag_q[14],
                      2'b00};
  wire [7:0] st_temp = {flag_q[15], flag_q[16], 6'h00};
  wire [7:0] st_comm = {flag_q[19], flag_q[20], 1'b0, 3'b000,
                        flag_q[21], 1'b0};
  wire [7:0] st_fan = {flag_q[17], 3'b000, {2{flag_q[18]}},
                       2'b00};
  wire any_temp = |st_temp;
  wire any_comm = |st_comm;
  wire [6:0] sum_hi = {i_busy, ~o_output_en, flag_q[1], flag_q[4],
                       flag_q[12], any_temp, any_comm};
  wire others = |st_vout | |st_iout | |st_in | |st_fan;
  wire [7:0] st_byte = {sum_hi,
                        others & ~(|sum_hi)};
  wire [7:0] st_high = {|st_vout, |st_iout, |st_in, 1'b0,
                        i_power_not_good, |st_fan,
                        2'b00};

  // read value of the addressed command
  always @* begin
    rd_two = 1'b1;
    case (cmd_q)
      `OFS_VOUT_UV_ACT, `OFS_OC_ACT, `OFS_VIN_OV_ACT,
      `OFS_VIN_UV_ACT: begin
        rd_val = {8'h00, `ACT_HICCUP};
        rd_two = 1'b0;
      end
      `OFS_OT_ACT: begin
        rd_val = {8'h00, ot_act_q};
        rd_two = 1'b0;
      end
      `OFS_STAT_WORD: rd_val = {st_high, st_byte};
      `OFS_STAT_BYTE: begin
        rd_val = {8'h00, st_byte};
        rd_two = 1'b0;
      end
      `OFS_STAT_VOUT: begin
        rd_val = {8'h00, st_vout};
        rd_two = 1'b0;
      end
      `OFS_STAT_IOUT: begin
        rd_val = {8'h00, st_iout};
        rd_two = 1'b0;
      end
      `OFS_STAT_INPUT: begin
        rd_val = {8'h00, st_in};
        rd_two = 1'b0;
      end
      `OFS_STAT_TEMP: begin
        rd_val = {8'h00, st_temp};
        rd_two = 1'b0;
      end
      `OFS_STAT_COMM: begin
        rd_val = {8'h00, st_comm};
        rd_two = 1'b0;
      end
      `OFS_STAT_FANS: begin
        rd_val = {8'h00, st_fan};
        rd_two = 1'b0;
      end
      default: begin
        if (lim_idx(cmd_q) != 4'd9)
          rd_val = lim_q[lim_idx(cmd_q)];
        else
          rd_val = {`RD_FILL, `RD_FILL};
      end
    endcase
  end

  // low byte first, then high, then fill
  always @* begin
    case (rptr_q)
      2'd0: rd_byte = rd_val[7:0];
      2'd1: rd_byte = rd_two ? rd_val[15:8] : `RD_FILL;
      default: rd_byte = `RD_FILL;
    endcase
  end
endmodule // fault_limit_status_bank

// ===== hdl/fault_bank_regs.vh
// register offsets, reset values and codes of the fault and status bank
`ifndef FAULT_BANK_REGS_VH
`define FAULT_BANK_REGS_VH

// commands
`define CMD_CLEAR_FAULTS 8'h03

// limit and response offsets
`define OFS_VOUT_UV_LVL 8'h44
`define OFS_VOUT_UV_ACT 8'h45
`define OFS_OC_LVL 8'h46
`define OFS_OC_ACT 8'h47
`define OFS_OC_WARN 8'h4a
`define OFS_OT_LVL 8'h4f
`define OFS_OT_ACT 8'h50
`define OFS_OT_WARN 8'h51
`define OFS_VIN_OV_LVL 8'h55
`define OFS_VIN_OV_ACT 8'h56
`define OFS_VIN_OV_WARN 8'h57
`define OFS_VIN_UV_WARN 8'h58
`define OFS_VIN_UV_LVL 8'h59
`define OFS_VIN_UV_ACT 8'h5a

// status offsets
`define OFS_STAT_BYTE 8'h78
`define OFS_STAT_WORD 8'h79
`define OFS_STAT_VOUT 8'h7a
`define OFS_STAT_IOUT 8'h7b
`define OFS_STAT_INPUT 8'h7c
`define OFS_STAT_TEMP 8'h7d
`define OFS_STAT_COMM 8'h7e
`define OFS_STAT_FANS 8'h81

// fault response codes
`define ACT_LATCHED 8'h80
`define ACT_HICCUP 8'hc0

// reset values; limits in whole units of the measurement inputs
`define RST_VOUT_UV_LVL 16'h000a
`define RST_OC_LVL 16'h0042
`define RST_OC_WARN 16'h003e
`define RST_OT_LVL 16'h0082
`define RST_OT_ACT 8'hc0
`define RST_OT_WARN 16'h0078
`define RST_VIN_OV_LVL 16'h004c
`define RST_VIN_OV_WARN 16'h004a
`define RST_VIN_UV_WARN 16'h0028
`define RST_VIN_UV_LVL 16'h0026
`define RST_STATUS 8'h00

// answer to a read past the register width
`define RD_FILL 8'hff

`endif

// ===== hdl/serial_byte_slave.v
// two-wire serial slave byte engine, oversampled by the system clock
`timescale 1ns/1ps
module serial_byte_slave #(
  parameter [6:0] ADDR = 7'h58
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda_oe,
  output reg o_start,
  output reg o_stop,
  output reg o_wr_stb,
  output reg [7:0] o_wr_data,
  output reg o_rd_next,
  input wire [7:0] i_rd_data
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_ACK = 3'd2;
  localparam [2:0] S_WBYTE = 3'd3;
  localparam [2:0] S_RBYTE = 3'd4;
  localparam [2:0] S_RACK = 3'd5;

  reg scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
  reg [2:0] st_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg rw_q, ack_on_q, more_q, oe_q;
  wire rise, fall, start, stop;

  // two-stage synchronisers, then edge history
  always @(posedge i_clk) begin
    if (i_rst) begin
      scl_m_q <= 1'b1;
      scl_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      scl_q <= scl_m_q;
      scl_p_q <= scl_q;
      sda_m_q <= i_sda;
      sda_q <= sda_m_q;
      sda_p_q <= sda_q;
    end
  end

  assign rise = scl_q & ~scl_p_q;
  assign fall = ~scl_q & scl_p_q;
  assign start = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop = scl_q & scl_p_q & ~sda_p_q & sda_q;
  assign o_sda_oe = oe_q;

  // bit and byte sequencing
  always @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= S_IDLE;
      cnt_q <= 3'd0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      more_q <= 1'b0;
      oe_q <= 1'b0;
      o_start <= 1'b0;
      o_stop <= 1'b0;
      o_wr_stb <= 1'b0;
      o_wr_data <= 8'h00;
      o_rd_next <= 1'b0;
    end else begin
      o_start <= start;
      o_stop <= stop;
      o_wr_stb <= 1'b0;
      o_rd_next <= 1'b0;
      if (start) begin
        st_q <= S_ADDR;
        cnt_q <= 3'd0;
        oe_q <= 1'b0;
      end else if (stop) begin
        st_q <= S_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          S_ADDR: if (rise) begin
            sh_q <= {sh_q[6:0], sda_q};
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              rw_q <= sda_q;
              ack_on_q <= 1'b0;
              st_q <= (sh_q[6:0] == ADDR) ? S_ACK : S_IDLE;
            end
          end
          S_WBYTE: if (rise) begin
            sh_q <= {sh_q[6:0], sda_q};
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              o_wr_stb <= 1'b1;
              o_wr_data <= {sh_q[6:0], sda_q};
              ack_on_q <= 1'b0;
              st_q <= S_ACK;
            end
          end
          S_ACK: if (fall) begin
            if (!ack_on_q) begin
              oe_q <= 1'b1; // pull low for acknowledge
              ack_on_q <= 1'b1;
            end else if (rw_q) begin
              sh_q <= i_rd_data;
              oe_q <= ~i_rd_data[7];
              o_rd_next <= 1'b1;
              cnt_q <= 3'd0;
              st_q <= S_RBYTE;
            end else begin
              oe_q <= 1'b0;
              cnt_q <= 3'd0;
              st_q <= S_WBYTE;
            end
          end
          S_RBYTE: if (fall) begin
            if (cnt_q == 3'd7) begin
              oe_q <= 1'b0;
              more_q <= 1'b0;
              st_q <= S_RACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
              cnt_q <= cnt_q + 3'd1;
            end
          end
          S_RACK: begin
            if (rise) begin
              if (sda_q)
                st_q <= S_IDLE; // master ends the read
              else
                more_q <= 1'b1;
            end else if (fall && more_q) begin
              sh_q <= i_rd_data;
              oe_q <= ~i_rd_data[7];
              o_rd_next <= 1'b1;
              cnt_q <= 3'd0;
              st_q <= S_RBYTE;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // serial_byte_slave

// ===== bench/bank_checker_assertions.sv
// port-level checks for the fault limit and status bank
`timescale 1ns/1ps
module bank_checker #(
  parameter N_TEMP = 3,
  parameter [15:0] LV_FAULT_LEVEL = 16'h0006
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_oe,
  input wire o_alert_n,
  input wire o_output_en,
  input wire [15:0] i_vout,
  input wire [15:0] i_iout,
  input wire [15:0] i_vin,
  input wire [16*N_TEMP-1:0] i_temps,
  input wire i_current_limiting,
  input wire i_vout_ov_warn
);
  logic hot;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // any sensor above the default temperature limit
  always_comb begin
    hot = 1'b0;
    for (int g = 0; g < N_TEMP; g++) begin
      if (i_temps[16*g+:16] > 16'h0082) hot = 1'b1;
    end
  end

  a_reset_quiet: assert property (
    $fell(i_rst) |-> o_alert_n && !o_output_en && !o_sda_oe)
    else $error("outputs not idle after reset");
  a_vin_ov_off: assert property (
    i_vin > 16'h004c |-> ##[1:2] !o_output_en)
    else $error("output on above input overvoltage limit");
  a_vin_uv_off: assert property (
    i_vin < 16'h0026 |-> ##[1:2] !o_output_en)
    else $error("output on below input undervoltage limit");
  a_oc_off: assert property (
    i_iout > 16'h0042 |-> ##[1:2] !o_output_en)
    else $error("output on above overcurrent limit");
  a_hot_off: assert property (
    hot |-> ##[1:2] !o_output_en)
    else $error("output on above temperature limit");
  a_lv_off: assert property (
    o_output_en && i_current_limiting && i_vout < LV_FAULT_LEVEL
    |-> ##[1:2] !o_output_en)
    else $error("output on in current limit at low voltage");
  a_warn_alert: assert property (
    i_vout_ov_warn |-> ##[1:3] !o_alert_n)
    else $error("alert not raised on warning");
  a_alert_sticky: assert property (
    (i_scl && i_sda) [*8] ##0 !o_alert_n |=> !o_alert_n)
    else $error("alert released while bus idle");

  // main scenarios reached
  cover property (i_vin > 16'h004c);
  cover property ($fell(o_alert_n));
  cover property (hot ##[1:2] !o_output_en);
endmodule // bank_checker

// ===== bench/host_model.sv
// host side of the two-wire management bus
`timescale 1ns/1ps
module host_model #(
  parameter [6:0] ADDR = 7'h58
) (
  input wire i_clk,
  input wire i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // idle bus: clock stands high, data released
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one bit, data set while clock low, sampled late in high phase
  task automatic b(input logic v, output logic r);
    o_sda_oe = !v;
    w(2);
    o_scl = 1'b1;
    w(4);
    r = i_sda;
    w(1);
    o_scl = 1'b0;
    w(3);
  endtask

  // start or repeated start
  task automatic start;
    o_sda_oe = 1'b0;
    w(2);
    o_scl = 1'b1;
    w(3);
    o_sda_oe = 1'b1;
    w(3);
    o_scl = 1'b0;
    w(2);
  endtask

  task automatic stop;
    o_sda_oe = 1'b1;
    w(2);
    o_scl = 1'b1;
    w(3);
    o_sda_oe = 1'b0;
    w(8);
  endtask

  // byte out msb first, then clock the acknowledge
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) b(d[i], r);
    b(1'b1, r);
  endtask

  // byte in, last one answered with not-acknowledge
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) b(1'b1, d[i]);
    b(last, r);
  endtask

  // write: command then n data bytes, low byte first
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
    start;
    tx({ADDR, 1'b0});
    tx(c);
    if (n > 0) tx(d[7:0]);
    if (n > 1) tx(d[15:8]);
    stop;
  endtask

  // read: command, repeated start, n bytes low first
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d);
    start;
    tx({ADDR, 1'b0});
    tx(c);
    start;
    tx({ADDR, 1'b1});
    d = 16'h0000;
    rx(n == 1, d[7:0]);
    if (n > 1) rx(1'b1, d[15:8]);
    stop;
  endtask
endmodule // host_model

// ===== bench/tb_top.sv
// testbench for the fault limit and status bank
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst, h_scl, h_oe, d_oe, alert_n, out_en;
  logic lost, clim, rstrt, busy, png, vovf, vovw, vuvw;
  logic shf, plim, iinoc, fanf, fano;
  logic [15:0] vout, iout, vin, d;
  logic [47:0] temps;
  int error_cnt, cmp_count;
  // data line pulled up unless a side pulls it low
  wire sda = !(h_oe || d_oe);

  fault_limit_status_bank fault_limit_status_bank_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(h_scl), .i_sda(sda),
    .o_sda(), .o_sda_oe(d_oe), .o_alert_n(alert_n), .o_output_en(out_en),
    .i_vout(vout), .i_iout(iout), .i_vin(vin), .i_temps(temps),
    .i_input_lost(lost), .i_current_limiting(clim), .i_restart(rstrt),
    .i_busy(busy), .i_power_not_good(png), .i_vout_ov_fault(vovf),
    .i_vout_ov_warn(vovw), .i_vout_uv_warn(vuvw), .i_share_fault(shf),
    .i_power_limiting(plim), .i_iin_over_current(iinoc),
    .i_fan1_fault(fanf), .i_fan_override(fano));
  host_model host_model_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(h_scl),
    .o_sda_oe(h_oe));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = !i_clk;
  end

  task automatic w(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] c, input int n, input logic [15:0] e);
    host_model_inst.rd(c, n, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input int n);
    host_model_inst.wr(c, v, n);
  endtask
  task automatic clr;
    wr(8'h03, 16'h0000, 0);
  endtask
  // output must drop within a few cycles
  task automatic went_off;
    logic s;
    s = 1'b0;
    repeat (6) begin
      @(negedge i_clk);
      if (out_en === 1'b0) s = 1'b1;
    end
    chk(16'(s), 16'h0001);
  endtask

  task automatic t_reset;
    rc(8'h44, 2, 16'h000a);
    rc(8'h45, 1, 16'h00c0);
    rc(8'h47, 1, 16'h00c0);
    rc(8'h50, 1, 16'h00c0);
    rc(8'h55, 2, 16'h004c);
    rc(8'h56, 1, 16'h00c0);
    rc(8'h57, 2, 16'h004a);
    rc(8'h58, 2, 16'h0028);
    rc(8'h59, 2, 16'h0026);
    rc(8'h5a, 1, 16'h00c0);
    rc(8'h79, 2, 16'h0000);
    rc(8'h7d, 1, 16'h0000);
    $display("done: reset values");
  endtask

  task automatic t_writes;
    wr(8'h50, 16'h0080, 1);
    rc(8'h50, 1, 16'h0080);
    wr(8'h50, 16'h0012, 1);
    rc(8'h50, 1, 16'h0080);
    rc(8'h7e, 1, 16'h0040);
    wr(8'h55, 16'h0050, 2);
    rc(8'h55, 2, 16'h004c);
    wr(8'h55, 16'h0048, 2);
    rc(8'h55, 2, 16'h0048);
    wr(8'h55, 16'h004c, 2);
    wr(8'h58, 16'h0020, 2);
    rc(8'h58, 2, 16'h0028);
    wr(8'h45, 16'h0080, 1);
    rc(8'h45, 1, 16'h00c0);
    clr;
    rc(8'h7e, 1, 16'h0000);
    wr(8'h30, 16'h0000, 0);
    rc(8'h7e, 2, 16'hff80);
    rc(8'h7e, 1, 16'h0082);
    rc(8'h78, 1, 16'h0002);
    clr;
    $display("done: register writes");
  endtask

  task automatic t_temp;
    temps[31:16] = 16'h007d;
    w(4);
    chk(16'(alert_n), 16'h0000);
    rc(8'h7d, 1, 16'h0040);
    temps[47:32] = 16'h0087;
    went_off;
    temps = {3{16'h0019}};
    w(20);
    chk(16'(out_en), 16'h0000);
    rc(8'h7d, 1, 16'h00c0);
    rc(8'h78, 1, 16'h0044);
    rstrt = 1'b1;
    w(1);
    rstrt = 1'b0;
    w(4);
    chk(16'(out_en), 16'h0001);
    wr(8'h50, 16'h00c0, 1);
    temps[15:0] = 16'h0087;
    went_off;
    temps[15:0] = 16'h0019;
    w(4);
    chk(16'(out_en), 16'h0001);
    clr;
    chk(16'(alert_n), 16'h0001);
    $display("done: temperature");
  endtask

  task automatic t_vin;
    vin = 16'h004b;
    w(4);
    rc(8'h7c, 1, 16'h0040);
    vin = 16'h0050;
    went_off;
    vin = 16'h0027;
    w(4);
    vin = 16'h0025;
    went_off;
    vin = 16'h0032;
    w(4);
    chk(16'(out_en), 16'h0001);
    host_model_inst.rd(8'h7c, 1, d);
    chk(d & 16'h00f0, 16'h00f0);
    clr;
    rc(8'h7c, 1, 16'h0000);
    $display("done: input voltage");
  endtask

  task automatic t_out;
    iout = 16'h0040;
    w(4);
    rc(8'h7b, 1, 16'h0020);
    iout = 16'h0046;
    went_off;
    iout = 16'h001e;
    w(4);
    rc(8'h7b, 1, 16'h00a0);
    clr;
    lost = 1'b1;
    vout = 16'h0008;
    w(4);
    chk(16'(out_en), 16'h0001);
    rc(8'h7a, 1, 16'h0000);
    lost = 1'b0;
    went_off;
    vout = 16'h000c;
    rc(8'h7a, 1, 16'h0010);
    host_model_inst.rd(8'h7c, 1, d);
    chk(d & 16'h0008, 16'h0008);
    clr;
    clim = 1'b1;
    vout = 16'h0005;
    went_off;
    rc(8'h7b, 1, 16'h0040);
    clim = 1'b0;
    vout = 16'h000c;
    clr;
    $display("done: output faults");
  endtask

  task automatic t_misc;
    {busy, png, vovf, vovw, vuvw} = 5'h1f;
    {shf, plim, iinoc, fanf, fano} = 5'h1f;
    w(4);
    rc(8'h7a, 1, 16'h00e0);
    rc(8'h7b, 1, 16'h000c);
    rc(8'h81, 1, 16'h008c);
    host_model_inst.rd(8'h7c, 1, d);
    chk(d & 16'h0004, 16'h0004);
    host_model_inst.rd(8'h79, 2, d);
    chk({6'h00, d[15:8], d[7], d[5]}, 16'h03b3);
    {busy, png, vovf, vovw, vuvw} = 5'h00;
    {shf, plim, iinoc, fanf, fano} = 5'h00;
    clr;
    rc(8'h81, 1, 16'h0000);
    $display("done: category flags");
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog at about three and a half times the expected run, under the cycle budget
  initial begin
    #600000;
    error_cnt++;
    give_verdict;
  end

  // reset, then the scenarios in turn
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    {lost, clim, rstrt, busy, png, vovf, vovw, vuvw} = 8'h00;
    {shf, plim, iinoc, fanf, fano} = 5'h00;
    vout = 16'h000c;
    iout = 16'h001e;
    vin = 16'h0032;
    temps = {3{16'h0019}};
    w(5);
    i_rst = 1'b0;
    w(4);
    t_reset;
    t_writes;
    t_temp;
    t_vin;
    t_out;
    t_misc;
    give_verdict;
  end
endmodule // tb_top

bind fault_limit_status_bank bank_checker #(.N_TEMP(N_TEMP),
  .LV_FAULT_LEVEL(LV_FAULT_LEVEL)) bank_checker_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_oe(o_sda_oe),
  .o_alert_n(o_alert_n), .o_output_en(o_output_en), .i_vout(i_vout),
  .i_iout(i_iout), .i_vin(i_vin), .i_temps(i_temps),
  .i_current_limiting(i_current_limiting),
  .i_vout_ov_warn(i_vout_ov_warn));
